//--- pkg/sesm_pkg.sv
// Constants, layouts and types of the status reporting block.
// Assumes a single clock domain and a synchronous reset.

package sesm_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STB    = 8'h04;
	localparam logic [7:0] ADDR_SPOLL  = 8'h08;
	localparam logic [7:0] ADDR_SRE    = 8'h0C;
	localparam logic [7:0] ADDR_ERRQ   = 8'h10;
	localparam logic [7:0] ADDR_OUTQ   = 8'h14;
	localparam logic [7:0] ADDR_QSTAT  = 8'h18;
	localparam logic [7:0] ADDR_CHAIN0 = 8'h40;
	localparam logic [7:0] CHAIN_SPAN  = 8'h20;

	// Offsets inside one chain window
	localparam logic [4:0] OFS_COND   = 5'h00;
	localparam logic [4:0] OFS_SUMEV  = 5'h04;
	localparam logic [4:0] OFS_SUMEN  = 5'h08;
	localparam logic [4:0] OFS_INSTEV = 5'h0C;
	localparam logic [4:0] OFS_INSTEN = 5'h10;
	localparam logic [4:0] OFS_EV     = 5'h14;
	localparam logic [4:0] OFS_EN     = 5'h18;

	// ----------------------------------------
	// Chains and field positions
	// ----------------------------------------
	localparam int NCHAIN      = 3;
	localparam int CH_OPER     = 0;
	localparam int CH_QUES     = 1;
	localparam int CH_MEAS     = 2;
	localparam int REG_W       = 16;
	localparam int BIT_IDLE    = 10;
	localparam int BIT_SUBSUM  = 1;
	localparam int BIT_INSTSUM = 13;

	localparam int CTRL_CLS    = 0;
	localparam int CTRL_ERRCLR = 1;

	localparam int STB_MEAS = 0;
	localparam int STB_EAV  = 2;
	localparam int STB_QUES = 3;
	localparam int STB_MAV  = 4;
	localparam int STB_RQS  = 6;
	localparam int STB_OPER = 7;

	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [15:0] REG_RST      = 16'h0000;
	localparam logic [7:0]  SRE_RST      = 8'h00;
	localparam logic [15:0] ERR_NONE     = 16'h0000;
	localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2;  // -350
	localparam int          ERR_DEPTH    = 64;
	localparam int          OUT_DEPTH    = 8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [REG_W-1:0] cond;
		logic [REG_W-1:0] sum_ev;
		logic [REG_W-1:0] sum_en;
		logic [REG_W-1:0] inst_ev;
		logic [REG_W-1:0] inst_en;
		logic [REG_W-1:0] ev;
		logic [REG_W-1:0] en;
	} sesm_chain_s;

	typedef struct packed {
		logic        empty;
		logic        full;
		logic [15:0] count;
	} sesm_qstat_s;

endpackage

//--- verilog/sesm_fifo.sv
// First-in first-out store of flip-flops with optional overflow marker.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sesm_fifo
	import sesm_pkg::*;
#(
	parameter int             W        = 16,
	parameter int             DEPTH    = 64,
	parameter bit             OVF_EN   = 1'b0,
	parameter logic [W-1:0]   OVF_CODE = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Control
	input  wire logic         push,
	input  wire logic [W-1:0] push_data,
	input  wire logic         pop,
	input  wire logic         clear,
	// State
	output logic [W-1:0]      head,
	output sesm_qstat_s       stat
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST  = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULLC = CW'(DEPTH);

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] count_q;
	logic          do_push;
	logic          do_pop;

	// ----------------------------------------
	// Flow control
	// ----------------------------------------
	// A full store drops the new item so older entries survive
	assign do_push = push && (count_q != FULLC) && !clear;
	assign do_pop  = pop && (count_q != '0) && !clear;

	always_ff @(posedge clk) begin
		if (do_push) begin
			if (OVF_EN && (count_q == FULLC - CW'(1))) begin
				mem_q[wr_q] <= OVF_CODE;
			end else begin
				mem_q[wr_q] <= push_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || clear) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= (wr_q == LAST) ? '0 : wr_q + AW'(1);
			end
			if (do_pop) begin
				rd_q <= (rd_q == LAST) ? '0 : rd_q + AW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || clear) begin
			count_q <= '0;
		end else if (do_push && !do_pop) begin
			count_q <= count_q + CW'(1);
		end else if (do_pop && !do_push) begin
			count_q <= count_q - CW'(1);
		end
	end

	// Empty store answers with a zero entry
	assign head       = (count_q != '0) ? mem_q[rd_q] : '0;
	assign stat.empty = (count_q == '0);
	assign stat.full  = (count_q == FULLC);
	assign stat.count = 16'(count_q);

endmodule

`default_nettype wire

//--- verilog/sesm_top.sv
// Status reporting block: event chains, status byte, service request, queues.
// Assumes an AXI4-Lite master on CLOCK and condition sources on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sesm_top
	import sesm_pkg::*;
#(
	parameter int ERR_DEPTH_P = ERR_DEPTH,
	parameter int OUT_DEPTH_P = OUT_DEPTH
) (
	// Clock and reset
	input  wire logic              CLOCK,
	input  wire logic              SRST,
	// AXI4-Lite write address and data
	input  wire logic [7:0]        AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	// AXI4-Lite write response
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	// AXI4-Lite read
	input  wire logic [7:0]        ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY,
	// Live instrument conditions
	input  wire logic [REG_W-1:0]  OPER_COND,
	input  wire logic [REG_W-1:0]  QUES_COND,
	input  wire logic [REG_W-1:0]  MEAS_COND,
	input  wire logic              INST_IDLE,
	// Queue sources
	input  wire logic              ERR_PUSH,
	input  wire logic signed [15:0] ERR_CODE,
	input  wire logic              OQ_PUSH,
	input  wire logic [31:0]       OQ_DATA,
	// Status outputs
	output logic [7:0]             STATUS_BYTE,
	output logic                   SRQ
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	sesm_chain_s      ch_q [NCHAIN];
	logic [REG_W-1:0] raw_cond [NCHAIN];
	logic [NCHAIN-1:0] chain_sum;

	logic        aw_have_q;
	logic        w_have_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_fire;
	logic        rd_fire;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_word;

	logic [7:0]  sre_q;
	logic        rqs_q;
	logic [7:0]  stb_bits;
	logic [7:0]  stb_en_q;
	logic        mss;
	logic        cls;
	logic        err_clr;
	logic        err_pop;
	logic        oq_pop;
	logic        spoll;

	logic [15:0] err_head;
	logic [31:0] oq_head;
	sesm_qstat_s err_stat;
	sesm_qstat_s oq_stat;

	logic [1:0]  chain_idx;
	logic [4:0]  chain_ofs;
	logic        chain_sel;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic in_chain(input logic [7:0] a);
		logic [7:0] top;
		top = ADDR_CHAIN0 + 8'(NCHAIN) * CHAIN_SPAN;
		in_chain = (a >= ADDR_CHAIN0) && (a < top) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic chain_ofs_ok(input logic [4:0] o);
		chain_ofs_ok = (o <= OFS_EN) && (o[1:0] == 2'h0) && (o[4:2] != 3'h7);
	endfunction

	function automatic logic hit(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - ADDR_CHAIN0;
		hit = (a == ADDR_CTRL) || (a == ADDR_STB) || (a == ADDR_SPOLL) || (a == ADDR_SRE) ||
		      (a == ADDR_ERRQ) || (a == ADDR_OUTQ) || (a == ADDR_QSTAT) ||
		      (in_chain(a) && chain_ofs_ok(rel[4:0]));
	endfunction

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	// Address and data are taken in either order, then answered together
	assign wr_fire = aw_have_q && w_have_q && !BVALID;
	assign wr_hit  = hit(aw_addr_q);

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			AWREADY   <= 1'b1;
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (AWVALID && AWREADY) begin
			AWREADY   <= 1'b0;
			aw_have_q <= 1'b1;
			aw_addr_q <= AWADDR;
		end else if (BVALID && BREADY) begin
			AWREADY   <= 1'b1;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			WREADY   <= 1'b1;
			w_have_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (WVALID && WREADY) begin
			WREADY   <= 1'b0;
			w_have_q <= 1'b1;
			w_data_q <= WDATA;
			w_strb_q <= WSTRB;
		end else if (BVALID && BREADY) begin
			WREADY   <= 1'b1;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			BVALID <= 1'b0;
			BRESP  <= RESP_OKAY;
		end else if (wr_fire) begin
			BVALID <= 1'b1;
			BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (BREADY) begin
			BVALID <= 1'b0;
		end
	end

	// Command strobes only come from the low byte
	assign cls     = wr_fire && (aw_addr_q == ADDR_CTRL) && w_strb_q[0] && w_data_q[CTRL_CLS];
	assign err_clr = wr_fire && (aw_addr_q == ADDR_CTRL) && w_strb_q[0] && w_data_q[CTRL_ERRCLR];

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// Side effects of a read happen once, at the address handshake
	assign rd_fire = ARVALID && ARREADY;
	assign rd_hit  = hit(ARADDR);
	assign spoll   = rd_fire && (ARADDR == ADDR_SPOLL);
	assign err_pop = rd_fire && (ARADDR == ADDR_ERRQ);
	assign oq_pop  = rd_fire && (ARADDR == ADDR_OUTQ);

	always_comb begin
		logic [7:0] rel;
		rel       = ARADDR - ADDR_CHAIN0;
		chain_idx = rel[6:5];
		chain_ofs = rel[4:0];
		chain_sel = in_chain(ARADDR);
		rd_word   = 32'h00000000;
		if (chain_sel) begin
			unique case (chain_ofs)
				OFS_COND:   rd_word[REG_W-1:0] = ch_q[chain_idx].cond;
				OFS_SUMEV:  rd_word[REG_W-1:0] = ch_q[chain_idx].sum_ev;
				OFS_SUMEN:  rd_word[REG_W-1:0] = ch_q[chain_idx].sum_en;
				OFS_INSTEV: rd_word[REG_W-1:0] = ch_q[chain_idx].inst_ev;
				OFS_INSTEN: rd_word[REG_W-1:0] = ch_q[chain_idx].inst_en;
				OFS_EV:     rd_word[REG_W-1:0] = ch_q[chain_idx].ev;
				OFS_EN:     rd_word[REG_W-1:0] = ch_q[chain_idx].en;
				default:    rd_word = 32'h00000000;
			endcase
		end else begin
			unique case (ARADDR)
				ADDR_STB:   rd_word[7:0] = {stb_bits[7], mss, stb_bits[5:0]};
				ADDR_SPOLL: rd_word[7:0] = {stb_bits[7], rqs_q, stb_bits[5:0]};
				ADDR_SRE:   rd_word[7:0] = sre_q;
				ADDR_ERRQ:  rd_word = {{16{err_head[15]}}, err_head};
				ADDR_OUTQ:  rd_word = oq_head;
				ADDR_QSTAT: rd_word = {oq_stat.count, err_stat.count};
				default:    rd_word = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
			RDATA   <= 32'h00000000;
			RRESP   <= RESP_OKAY;
		end else if (rd_fire) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RDATA   <= rd_word;
			RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
		end
	end

	// ----------------------------------------
	// Event chains
	// ----------------------------------------
	assign raw_cond[CH_OPER] = {OPER_COND[REG_W-1:BIT_IDLE+1], INST_IDLE, OPER_COND[BIT_IDLE-1:0]};
	assign raw_cond[CH_QUES] = QUES_COND;
	assign raw_cond[CH_MEAS] = MEAS_COND;

	for (genvar c = 0; c < NCHAIN; c++) begin : g_chain
		localparam logic [7:0] BASE = ADDR_CHAIN0 + 8'(c) * CHAIN_SPAN;

		logic [REG_W-1:0] rise;
		logic [REG_W-1:0] inst_set;
		logic [REG_W-1:0] top_set;
		logic             rd_sumev;
		logic             rd_instev;
		logic             rd_ev;
		logic             wr_here;

		assign rise      = raw_cond[c] & ~ch_q[c].cond;
		assign inst_set  = (|(ch_q[c].sum_ev & ch_q[c].sum_en)) ? REG_W'(1 << BIT_SUBSUM) : '0;
		assign top_set   = (ch_q[c].inst_ev[BIT_SUBSUM] && ch_q[c].inst_en[BIT_SUBSUM])
		                   ? REG_W'(1 << BIT_INSTSUM) : '0;
		assign rd_sumev  = rd_fire && (ARADDR == BASE + 8'(OFS_SUMEV));
		assign rd_instev = rd_fire && (ARADDR == BASE + 8'(OFS_INSTEV));
		assign rd_ev     = rd_fire && (ARADDR == BASE + 8'(OFS_EV));
		assign wr_here   = wr_fire && w_strb_q[0] && w_strb_q[1];

		// Conditions are sampled every cycle, never held
		always_ff @(posedge CLOCK) begin
			if (SRST) begin
				ch_q[c].cond <= REG_RST;
			end else begin
				ch_q[c].cond <= raw_cond[c];
			end
		end

		// A new event in the clearing cycle is kept; clear-status also cuts the summary from below
		always_ff @(posedge CLOCK) begin
			if (SRST) begin
				ch_q[c].sum_ev  <= REG_RST;
				ch_q[c].inst_ev <= REG_RST;
				ch_q[c].ev      <= REG_RST;
			end else begin
				ch_q[c].sum_ev  <= ((rd_sumev || cls) ? REG_RST : ch_q[c].sum_ev) | rise;
				ch_q[c].inst_ev <= ((rd_instev || cls) ? REG_RST : ch_q[c].inst_ev) | (cls ? REG_RST : inst_set);
				ch_q[c].ev      <= ((rd_ev || cls) ? REG_RST : ch_q[c].ev) | (cls ? REG_RST : top_set);
			end
		end

		always_ff @(posedge CLOCK) begin
			if (SRST) begin
				ch_q[c].sum_en  <= REG_RST;
				ch_q[c].inst_en <= REG_RST;
				ch_q[c].en      <= REG_RST;
			end else if (wr_here) begin
				if (aw_addr_q == BASE + 8'(OFS_SUMEN)) begin
					ch_q[c].sum_en <= w_data_q[REG_W-1:0];
				end
				if (aw_addr_q == BASE + 8'(OFS_INSTEN)) begin
					ch_q[c].inst_en <= w_data_q[REG_W-1:0];
				end
				if (aw_addr_q == BASE + 8'(OFS_EN)) begin
					ch_q[c].en <= w_data_q[REG_W-1:0];
				end
			end
		end

		assign chain_sum[c] = |(ch_q[c].ev & ch_q[c].en);
	end

	// ----------------------------------------
	// Queues
	// ----------------------------------------
	sesm_fifo #(
		.W        (16),
		.DEPTH    (ERR_DEPTH_P),
		.OVF_EN   (1'b1),
		.OVF_CODE (ERR_OVERFLOW)
	) u_err_q (
		.clk       (CLOCK),
		.srst      (SRST),
		.push      (ERR_PUSH),
		.push_data (ERR_CODE),
		.pop       (err_pop),
		.clear     (cls || err_clr),
		.head      (err_head),
		.stat      (err_stat)
	);

	// No overflow marker here: a full output queue simply drops replies
	sesm_fifo #(
		.W        (32),
		.DEPTH    (OUT_DEPTH_P),
		.OVF_EN   (1'b0),
		.OVF_CODE (32'h00000000)
	) u_out_q (
		.clk       (CLOCK),
		.srst      (SRST),
		.push      (OQ_PUSH),
		.push_data (OQ_DATA),
		.pop       (oq_pop),
		.clear     (1'b0),
		.head      (oq_head),
		.stat      (oq_stat)
	);

	// ----------------------------------------
	// Status byte and service request
	// ----------------------------------------
	always_comb begin
		stb_bits           = 8'h00;
		stb_bits[STB_MEAS] = chain_sum[CH_MEAS];
		stb_bits[STB_EAV]  = !err_stat.empty;
		stb_bits[STB_QUES] = chain_sum[CH_QUES];
		stb_bits[STB_MAV]  = !oq_stat.empty;
		stb_bits[STB_OPER] = chain_sum[CH_OPER];
	end

	// Bit 6 of the enable register has no meaning and is never enabled
	assign mss = |(stb_bits & sre_q & ~8'h40);

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			sre_q <= SRE_RST;
		end else if (wr_fire && (aw_addr_q == ADDR_SRE) && w_strb_q[0]) begin
			sre_q <= w_data_q[7:0] & ~8'h40;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			stb_en_q <= 8'h00;
		end else begin
			stb_en_q <= stb_bits & sre_q;
		end
	end

	// A rising enabled bit in the poll cycle still requests service
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rqs_q <= 1'b0;
		end else if (|(stb_bits & sre_q & ~stb_en_q)) begin
			rqs_q <= 1'b1;
		end else if (spoll) begin
			rqs_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			STATUS_BYTE <= 8'h00;
			SRQ         <= 1'b0;
		end else begin
			STATUS_BYTE <= {stb_bits[7], rqs_q, stb_bits[5:0]};
			SRQ         <= rqs_q;
		end
	end

endmodule

`default_nettype wire

//--- verif/sesm_chk_sva.sv
// Concurrent checks on the ports of the status reporting block.
// Assumes it is bound to sesm_top and that one clock serves all ports.
`timescale 1ns/1ps
`default_nettype none

module sesm_chk
	import sesm_pkg::*;
(
	// Clock and reset
	input wire logic       CLOCK,
	input wire logic       SRST,
	// Bus
	input wire logic       AWVALID,
	input wire logic       AWREADY,
	input wire logic       WVALID,
	input wire logic       WREADY,
	input wire logic       BVALID,
	input wire logic [7:0] ARADDR,
	input wire logic       ARVALID,
	input wire logic       ARREADY,
	input wire logic       RVALID,
	// Status
	input wire logic       ERR_PUSH,
	input wire logic       OQ_PUSH,
	input wire logic [7:0] STATUS_BYTE,
	input wire logic       SRQ
);
	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);

	sequence s_wtake;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence s_poll;
		ARVALID && ARREADY && ARADDR == ADDR_SPOLL;
	endsequence

	property p_rst_clear; $fell(SRST) |-> STATUS_BYTE == 8'h00 && !SRQ; endproperty
	property p_eav; ERR_PUSH |-> ##[1:3] STATUS_BYTE[STB_EAV]; endproperty
	property p_mav; OQ_PUSH |-> ##[1:3] STATUS_BYTE[STB_MAV]; endproperty
	property p_srq_set; $rose(STATUS_BYTE[STB_RQS]) |-> ##[0:1] SRQ; endproperty
	property p_srq_drop; $fell(STATUS_BYTE[STB_RQS]) |-> ##[0:1] !SRQ; endproperty
	// A new event in the poll window would re-raise the request; the bench avoids that
	property p_poll; s_poll |-> ##[1:3] !SRQ; endproperty
	property p_rd; ARVALID && ARREADY |=> RVALID; endproperty
	property p_wr; s_wtake |-> ##[1:2] BVALID; endproperty
	property p_wbusy; BVALID |-> !AWREADY && !WREADY; endproperty

	a_rst_clear: assert property (p_rst_clear) else $error("status not clear after reset");
	a_eav: assert property (p_eav) else $error("error available bit missing");
	a_mav: assert property (p_mav) else $error("message available bit missing");
	a_srq_set: assert property (p_srq_set) else $error("service request not raised");
	a_srq_drop: assert property (p_srq_drop) else $error("service request not dropped");
	a_poll: assert property (p_poll) else $error("serial poll left request set");
	a_rd: assert property (p_rd) else $error("read answer late");
	a_wr: assert property (p_wr) else $error("write answer late");
	a_wbusy: assert property (p_wbusy) else $error("write accepted while busy");
endmodule

`default_nettype wire

//--- verif/sesm_host.sv
// Host controller model: register reads and writes over AXI4-Lite.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none

module sesm_host (
	// Clock
	input wire logic         clk,
	// Bus
	output var logic [7:0]   awaddr,
	output var logic         awvalid,
	input wire logic         awready,
	output var logic [31:0]  wdata,
	output var logic [3:0]   wstrb,
	output var logic         wvalid,
	input wire logic         wready,
	input wire logic [1:0]   bresp,
	input wire logic         bvalid,
	output var logic         bready,
	output var logic [7:0]   araddr,
	output var logic         arvalid,
	input wire logic         arready,
	input wire logic [31:0]  rdata,
	input wire logic [1:0]   rresp,
	input wire logic         rvalid,
	output var logic         rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask

	// Each read of a queue window removes the word it returns
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

`default_nettype wire

//--- verif/test_status_event_srq_model.sv
// Self-checking bench of the status reporting block.
// Assumes the host model drives the bus; conditions and queues are driven here.
`timescale 1ns/1ps
`default_nettype none

module test_status_event_srq_model;
	import sesm_pkg::*;
	logic CLOCK = 0, SRST = 1, INST_IDLE = 0, ERR_PUSH = 0, OQ_PUSH = 0;
	logic [15:0] OPER_COND = 0, QUES_COND = 0, MEAS_COND = 0;
	logic signed [15:0] ERR_CODE = 0;
	logic [31:0] OQ_DATA = 0, WDATA, RDATA, d;
	logic [7:0] AWADDR, ARADDR, STATUS_BYTE;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, r;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY, SRQ;
	int err_total = 0, checked = 0;
	logic [7:0] base;
	logic [15:0] en_bit [3] = '{16'h0400, 16'h0001, 16'h0100};
	int stb_bit [3] = '{STB_OPER, STB_QUES, STB_MEAS};

	sesm_top #(.ERR_DEPTH_P(ERR_DEPTH), .OUT_DEPTH_P(OUT_DEPTH)) uut (.CLOCK(CLOCK), .SRST(SRST), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .OPER_COND(OPER_COND),
		.QUES_COND(QUES_COND), .MEAS_COND(MEAS_COND), .INST_IDLE(INST_IDLE), .ERR_PUSH(ERR_PUSH),
		.ERR_CODE(ERR_CODE), .OQ_PUSH(OQ_PUSH), .OQ_DATA(OQ_DATA), .STATUS_BYTE(STATUS_BYTE), .SRQ(SRQ));
	sesm_host host (.clk(CLOCK), .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY), .wdata(WDATA),
		.wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY), .bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
		.araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY), .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID),
		.rready(RREADY));

	initial forever #2 CLOCK = ~CLOCK;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		host.rd(a, d, r);
		chk(d, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	task automatic epush(input logic signed [15:0] c);
		@(posedge CLOCK);
		ERR_PUSH <= 1'b1;
		ERR_CODE <= c;
		@(posedge CLOCK);
		ERR_PUSH <= 1'b0;
	endtask
	task automatic finish_test;
		$display("Counts: %0d compares, %0d mismatches", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Bounded by a generous multiple of the expected run length
	initial begin
		#200000;
		err_total++;
		finish_test;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		cyc(12);
		SRST <= 1'b0;
		cyc(2);
		chk(STATUS_BYTE, 8'h00);
		rdc(ADDR_ERRQ, 32'h0);
		rdc(ADDR_QSTAT, 32'h0);
		chk(r, RESP_OKAY);
		host.rd(8'hFC, d, r);
		chk(r, RESP_SLVERR);
		$display("test reset done");
		@(posedge CLOCK) QUES_COND <= 16'h00A5;
		INST_IDLE <= 1'b1;
		OPER_COND <= 16'h0400;
		cyc(2);
		rdc(ADDR_CHAIN0 + CHAIN_SPAN + OFS_COND, 32'h00A5);
		rdc(ADDR_CHAIN0 + OFS_COND, 32'h0400);
		@(posedge CLOCK) INST_IDLE <= 1'b0;
		cyc(2);
		rdc(ADDR_CHAIN0 + OFS_COND, 32'h0);
		@(posedge CLOCK) QUES_COND <= 16'h0000;
		OPER_COND <= 16'h0000;
		$display("test conditions done");
		for (int c = 0; c < NCHAIN; c++) begin
			base = ADDR_CHAIN0 + CHAIN_SPAN * c[7:0];
			host.wr(ADDR_CTRL, 32'h1, r);
			host.wr(base + OFS_SUMEN, {16'h0, en_bit[c]}, r);
			host.wr(base + OFS_INSTEN, 32'h2, r);
			host.wr(base + OFS_EN, 32'h2000, r);
			host.wr(ADDR_SRE, 32'h1 << stb_bit[c], r);
			@(posedge CLOCK);
			case (c)
				0: INST_IDLE <= 1'b1;
				1: QUES_COND <= 16'h0001;
				default: MEAS_COND <= 16'h0100;
			endcase
			cyc(10);
			chk(STATUS_BYTE[stb_bit[c]], 1'b1);
			chk(SRQ, 1'b1);
			host.rd(ADDR_SPOLL, d, r);
			chk(d & 32'h40, 32'h40);
			cyc(3);
			chk(SRQ, 1'b0);
			host.rd(ADDR_STB, d, r);
			chk(d & 32'h40, 32'h40);
			rdc(base + OFS_EV, 32'h2000);
			rdc(base + OFS_SUMEV, {16'h0, en_bit[c]});
			rdc(base + OFS_SUMEV, 32'h0);
			@(posedge CLOCK) {INST_IDLE, QUES_COND, MEAS_COND} <= '0;
		end
		host.wr(ADDR_CTRL, 32'h1, r);
		cyc(4);
		rdc(ADDR_STB, 32'h0);
		rdc(ADDR_CHAIN0 + 8'd2 * CHAIN_SPAN + OFS_EV, 32'h0);
		$display("test chains done");
		for (int i = 0; i < 3; i++) begin
			@(posedge CLOCK) OQ_PUSH <= 1'b1;
			OQ_DATA <= 32'hA0 + i;
		end
		@(posedge CLOCK) OQ_PUSH <= 1'b0;
		cyc(3);
		chk(STATUS_BYTE[STB_MAV], 1'b1);
		for (int i = 0; i < 3; i++) rdc(ADDR_OUTQ, 32'hA0 + i);
		cyc(3);
		chk(STATUS_BYTE[STB_MAV], 1'b0);
		$display("test output queue done");
		epush(-16'sd100);
		epush(16'sd5);
		cyc(3);
		chk(STATUS_BYTE[STB_EAV], 1'b1);
		rdc(ADDR_ERRQ, 32'hFFFFFF9C);
		rdc(ADDR_ERRQ, 32'h5);
		for (int i = 1; i <= 66; i++) epush(16'(i));
		rdc(ADDR_QSTAT, 32'h40);
		for (int i = 1; i <= 63; i++) rdc(ADDR_ERRQ, i);
		rdc(ADDR_ERRQ, 32'hFFFFFEA2);
		rdc(ADDR_ERRQ, 32'h0);
		cyc(3);
		chk(STATUS_BYTE[STB_EAV], 1'b0);
		epush(16'sd7);
		host.wr(ADDR_CTRL, 32'h2, r);
		chk(r, RESP_OKAY);
		rdc(ADDR_QSTAT, 32'h0);
		epush(16'sd8);
		host.wr(ADDR_CTRL, 32'h1, r);
		rdc(ADDR_QSTAT, 32'h0);
		host.wr(8'hFC, 32'h1, r);
		chk(r, RESP_SLVERR);
		$display("test error queue done");
		finish_test;
	end
endmodule

bind sesm_top sesm_chk u_chk (.CLOCK(CLOCK), .SRST(SRST), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARADDR(ARADDR), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RVALID(RVALID), .ERR_PUSH(ERR_PUSH), .OQ_PUSH(OQ_PUSH),
	.STATUS_BYTE(STATUS_BYTE), .SRQ(SRQ));

`default_nettype wire
